// ### verilog/dma_irq_params.svh
// register offsets, field positions and reset values of the dma irq block
`ifndef DMA_IRQ_PARAMS_SVH
`define DMA_IRQ_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFF_COMB_MASKED 12'h000
`define OFF_TC_MASKED 12'h004
`define OFF_TC_CLEAR 12'h008
`define OFF_ERR_MASKED 12'h00C
`define OFF_ERR_CLEAR 12'h010
`define OFF_TC_RAW 12'h014
`define OFF_ERR_RAW 12'h018
`define OFF_CHAN_ON 12'h01C
`define OFF_SW_BURST 12'h020
`define OFF_SW_SINGLE 12'h024
`define OFF_SW_LAST_BURST 12'h028
`define OFF_SW_LAST_SINGLE 12'h02C
`define OFF_EVT_STATUS 12'h040
`define OFF_EVT_MASK 12'h044

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define EVT_BIT_TC 0
`define EVT_BIT_ERR 1
`define EVT_BIT_SW_DONE 2
`define RST_CH 8'h00
`define RST_SRC 16'h0000
`define RST_EVT 3'h0
`define RST_WORD 32'h0000_0000

`endif

// ### verilog/dma_irq_pkg.sv
// types shared by the dma irq and software request block
package dma_irq_pkg;
    localparam int NUM_CH = 8;
    localparam int NUM_SRC = 16;
    localparam int NUM_EVT = 3;

    // one bit per source for each request kind
    typedef struct packed {
        logic [NUM_SRC-1:0] burst;
        logic [NUM_SRC-1:0] single;
        logic [NUM_SRC-1:0] last_burst;
        logic [NUM_SRC-1:0] last_single;
    } req_vec_t;

    // per-channel completion and error events or masks
    typedef struct packed {
        logic [NUM_CH-1:0] tc;
        logic [NUM_CH-1:0] err;
    } chan_vec_t;
endpackage

// ### verilog/dma_irq_regs.sv
// dma interrupt flags, channel status and software request registers
//
// Overview of operation
// - tc clear write clears each terminal-count flag whose data bit is one
// - error clear write clears each error flag whose data bit is one
// - error masked status reads error flags anded with mask
// - raw tc status shows terminal-count flags before masking
// - raw error status shows error flags before masking
// - enabled status mirrors each channel's configuration enable bit
// - enabled status bit clears when that channel's transfer completes
// - writing one to burst register raises burst request
// - writing one to single register raises single request
// - writing one to last-burst register raises last-burst request
// - writing one to last-single register raises last-single request
// - software request bits clear when serving transaction completes
// - zero bits written to request registers change nothing
// - request register reads show software-set pending sources of that kind, not hardware lines
// - hardware line and software bit raise the same request
// - combined status is masked tc or masked error per channel
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "dma_irq_params.svh"

module dma_irq_regs
    import dma_irq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire chan_vec_t chan_event,
    input wire chan_vec_t chan_mask,
    input wire logic [NUM_CH-1:0] channel_config,
    input wire logic [NUM_CH-1:0] chan_done,
    input wire req_vec_t hw_req,
    input wire logic [NUM_SRC-1:0] req_done,
    output req_vec_t req_out,
    output logic tc_irq_out,
    output logic error_irq_out,
    output logic combined_irq_out,
    output logic evt_irq_out
);

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = (a == off);
    endfunction

    logic wr_acc;
    logic rd_acc;
    logic setup;
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;

    // ----------------------------------------------------------------
    // interrupt flags
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0] tc_flag_r;
    logic [NUM_CH-1:0] err_flag_r;
    logic [NUM_CH-1:0] tc_clr;
    logic [NUM_CH-1:0] err_clr;
    logic [NUM_CH-1:0] tc_masked;
    logic [NUM_CH-1:0] err_masked;
    logic [NUM_CH-1:0] comb_masked;

    assign tc_clr = (wr_acc && hit(paddr, `OFF_TC_CLEAR)) ?
                    pwdata[NUM_CH-1:0] : `RST_CH;
    assign err_clr = (wr_acc && hit(paddr, `OFF_ERR_CLEAR)) ?
                     pwdata[NUM_CH-1:0] : `RST_CH;
    assign tc_masked = tc_flag_r & chan_mask.tc;
    assign err_masked = err_flag_r & chan_mask.err;
    assign comb_masked = tc_masked | err_masked;

    // a new event in the clearing cycle wins so it is never lost
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tc_flag_r <= `RST_CH;
            err_flag_r <= `RST_CH;
        end else begin
            tc_flag_r <= (tc_flag_r & ~tc_clr) | chan_event.tc;
            err_flag_r <= (err_flag_r & ~err_clr) | chan_event.err;
        end
    end

    // registered so the irq lines are glitch free
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tc_irq_out <= 1'b0;
            error_irq_out <= 1'b0;
            combined_irq_out <= 1'b0;
        end else begin
            tc_irq_out <= |tc_masked;
            error_irq_out <= |err_masked;
            combined_irq_out <= |comb_masked;
        end
    end

    // ----------------------------------------------------------------
    // enabled channel status
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0] chan_on_r;
    logic [NUM_CH-1:0] cfg_d_r;

    // completion drops the bit even while the enable input stays high;
    // it comes back only on a fresh enable edge
    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    chan_on_r[c] <= 1'b0;
                    cfg_d_r[c] <= 1'b0;
                end else begin
                    cfg_d_r[c] <= channel_config[c];
                    if (chan_done[c]) begin
                        chan_on_r[c] <= 1'b0;
                    end else if (channel_config[c] && !cfg_d_r[c]) begin
                        chan_on_r[c] <= 1'b1;
                    end else if (!channel_config[c]) begin
                        chan_on_r[c] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // hardware request synchronisers
    // ----------------------------------------------------------------
    req_vec_t hw_s1_r;
    req_vec_t hw_s2_r;
    req_vec_t hw_s3_r;
    req_vec_t hw_filt_r;

    // a change counts only when the second and third stage agree
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hw_s1_r <= '0;
            hw_s2_r <= '0;
            hw_s3_r <= '0;
            hw_filt_r <= '0;
        end else begin
            hw_s1_r <= hw_req;
            hw_s2_r <= hw_s1_r;
            hw_s3_r <= hw_s2_r;
            hw_filt_r <= (hw_s2_r & hw_s3_r) |
                         (hw_filt_r & (hw_s2_r ^ hw_s3_r));
        end
    end

    // ----------------------------------------------------------------
    // software request registers, index 3 burst .. 0 last single
    // ----------------------------------------------------------------
    logic [3:0][NUM_SRC-1:0] sw_r;
    logic [3:0][NUM_SRC-1:0] sw_set;
    logic [NUM_SRC-1:0] sw_any;

    generate
        for (genvar t = 0; t < 4; t++) begin : g_sw
            localparam logic [11:0] OFF =
                12'(`OFF_SW_BURST + 4 * (3 - t));
            assign sw_set[t] = (wr_acc && hit(paddr, OFF)) ?
                               pwdata[NUM_SRC-1:0] : `RST_SRC;
            // set beats the completion clear in the same cycle
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    sw_r[t] <= `RST_SRC;
                end else begin
                    sw_r[t] <= (sw_r[t] & ~req_done) | sw_set[t];
                end
            end
        end
    endgenerate

    assign sw_any = sw_r[3] | sw_r[2] | sw_r[1] | sw_r[0];

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            req_out <= '0;
        end else begin
            req_out <= hw_filt_r | req_vec_t'(sw_r);
        end
    end

    // ----------------------------------------------------------------
    // event status, read to clear, with mask and one irq line
    // ----------------------------------------------------------------
    logic [NUM_EVT-1:0] evt_r;
    logic [NUM_EVT-1:0] evt_mask_r;
    logic [NUM_EVT-1:0] evt_set;
    logic evt_rd;

    always_comb begin
        evt_set = `RST_EVT;
        evt_set[`EVT_BIT_TC] = |chan_event.tc;
        evt_set[`EVT_BIT_ERR] = |chan_event.err;
        evt_set[`EVT_BIT_SW_DONE] = |(req_done & sw_any);
    end
    assign evt_rd = rd_acc && hit(paddr, `OFF_EVT_STATUS);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            evt_r <= `RST_EVT;
        end else if (evt_rd) begin
            // only the bits shown in prdata are cleared, so an event
            // landing on the setup edge survives the read
            evt_r <= (evt_r & ~prdata[NUM_EVT-1:0]) | evt_set;
        end else begin
            evt_r <= evt_r | evt_set;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            evt_mask_r <= `RST_EVT;
        end else if (wr_acc && hit(paddr, `OFF_EVT_MASK)) begin
            evt_mask_r <= pwdata[NUM_EVT-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            evt_irq_out <= 1'b0;
        end else begin
            evt_irq_out <= |(evt_r & evt_mask_r);
        end
    end

    // ----------------------------------------------------------------
    // read mux, sampled in the setup phase
    // ----------------------------------------------------------------
    logic [31:0] rd_nxt;
    logic miss_nxt;
    logic miss_r;

    // undefined upper bits read as zero
    always_comb begin
        rd_nxt = `RST_WORD;
        miss_nxt = 1'b0;
        case (paddr)
            `OFF_COMB_MASKED: rd_nxt[NUM_CH-1:0] = comb_masked;
            `OFF_TC_MASKED: rd_nxt[NUM_CH-1:0] = tc_masked;
            `OFF_ERR_MASKED: rd_nxt[NUM_CH-1:0] = err_masked;
            `OFF_TC_RAW: rd_nxt[NUM_CH-1:0] = tc_flag_r;
            `OFF_ERR_RAW: rd_nxt[NUM_CH-1:0] = err_flag_r;
            `OFF_CHAN_ON: rd_nxt[NUM_CH-1:0] = chan_on_r;
            `OFF_SW_BURST: rd_nxt[NUM_SRC-1:0] = sw_r[3];
            `OFF_SW_SINGLE: rd_nxt[NUM_SRC-1:0] = sw_r[2];
            `OFF_SW_LAST_BURST: rd_nxt[NUM_SRC-1:0] = sw_r[1];
            `OFF_SW_LAST_SINGLE: rd_nxt[NUM_SRC-1:0] = sw_r[0];
            `OFF_EVT_STATUS: rd_nxt[NUM_EVT-1:0] = evt_r;
            `OFF_EVT_MASK: rd_nxt[NUM_EVT-1:0] = evt_mask_r;
            `OFF_TC_CLEAR,
            `OFF_ERR_CLEAR: rd_nxt = `RST_WORD;
            default: miss_nxt = 1'b1;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= `RST_WORD;
            miss_r <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? `RST_WORD : rd_nxt;
            miss_r <= miss_nxt;
        end
    end

    // zero wait states keep the master simple
    assign pready = 1'b1;
    assign pslverr = psel & penable & miss_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_tc_clear_ones: assert property (
        tc_clr != `RST_CH && chan_event.tc == `RST_CH |=>
        (tc_flag_r & $past(tc_clr)) == `RST_CH)
        else $error("tc flag survived its clear");
    a_err_clear_ones: assert property (
        err_clr != `RST_CH && chan_event.err == `RST_CH |=>
        (err_flag_r & $past(err_clr)) == `RST_CH &&
        (err_flag_r & ~$past(err_clr)) == $past(err_flag_r & ~err_clr))
        else $error("error clear wrong");
    a_err_masked_read: assert property (
        setup && !pwrite && paddr == `OFF_ERR_MASKED |=>
        prdata == {24'h00_0000, $past(err_flag_r & chan_mask.err)})
        else $error("masked error read wrong");
    a_tc_raw_read: assert property (
        setup && !pwrite && paddr == `OFF_TC_RAW |=>
        prdata == {24'h00_0000, $past(tc_flag_r)})
        else $error("raw tc read wrong");
    a_chan_done_off: assert property (
        chan_done != `RST_CH |=> (chan_on_r & $past(chan_done)) == `RST_CH)
        else $error("channel still on after done");
    a_sw_burst_set: assert property (
        sw_set[3] != `RST_SRC |=>
        (sw_r[3] & $past(sw_set[3])) == $past(sw_set[3]))
        else $error("burst request not raised");
    a_sw_zero_keeps: assert property (
        wr_acc && req_done == `RST_SRC |=> sw_r == $past(sw_r | sw_set))
        else $error("software write cancelled a request");
    a_sw_auto_clear: assert property (
        req_done != `RST_SRC && sw_set[2] == `RST_SRC |=>
        (sw_r[2] & $past(req_done)) == `RST_SRC)
        else $error("single request not cleared on completion");
    a_hw_req_merge: assert property (
        hw_req.single[0] [*6] |=> req_out.single[0])
        else $error("hardware request not forwarded");
    a_comb_irq_follow: assert property (
        ##1 combined_irq_out == $past(|(tc_masked | err_masked)))
        else $error("combined irq wrong");
    a_tc_irq_follow: assert property (
        ##1 tc_irq_out == $past(|(tc_flag_r & chan_mask.tc)))
        else $error("tc irq wrong");

    c_tc_set_clear: cover property (
        |chan_event.tc ##[1:20] tc_clr != `RST_CH);
    c_sw_served: cover property (
        sw_set[2] != `RST_SRC ##[1:20] |(req_done & sw_r[2]));
    c_evt_irq: cover property (evt_irq_out ##[1:20] evt_rd);
    c_sw_done_evt: cover property (
        evt_set[`EVT_BIT_SW_DONE] ##1 evt_r[`EVT_BIT_SW_DONE]);

endmodule

`default_nettype wire

// ### dv/dma_periph_model.sv
// peripheral side model: hardware request lines and completion pulses
`timescale 1ns/100ps
`default_nettype none

module dma_periph_model
    import dma_irq_pkg::*;
(
    input wire logic ref_clk,
    output var req_vec_t hw_req,
    output var logic [NUM_SRC-1:0] req_done
);
    initial begin
        hw_req = '0;
        req_done = '0;
    end

    // ----------------------------------------------------------------
    // request lines
    // ----------------------------------------------------------------
    // kind 0..3 is burst, single, last burst, last single; a level is
    // held until the peripheral drops it, as a real request line is
    task automatic set_req(input int kind, input int src, input logic lvl);
        @(posedge ref_clk);
        hw_req[(3-kind)*NUM_SRC+src] <= lvl;
    endtask

    // ----------------------------------------------------------------
    // completion
    // ----------------------------------------------------------------
    // lag lets the bench mix prompt and slow service of a request
    task automatic serve(input logic [NUM_SRC-1:0] src, input int lag);
        repeat (lag) @(posedge ref_clk);
        @(posedge ref_clk);
        req_done <= src;
        @(posedge ref_clk);
        req_done <= '0;
    endtask
endmodule

`default_nettype wire

// ### dv/dma_irq_and_soft_request_regs_tb_top.sv
// self-checking bench for the dma irq and software request registers
`timescale 1ns/100ps
`default_nettype none
`include "dma_irq_params.svh"

module dma_irq_and_soft_request_regs_tb_top
    import dma_irq_pkg::*;
();
    logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, errv;
    logic [11:0] paddr, a;
    logic [31:0] pwdata, prdata, rdv;
    chan_vec_t chan_event, chan_mask;
    logic [NUM_CH-1:0] channel_config, chan_done;
    req_vec_t hw_req, req_out;
    logic [NUM_SRC-1:0] req_done;
    logic tc_irq_out, error_irq_out, combined_irq_out, evt_irq_out;
    int bad_count, n_tests;

    dma_irq_regs DUT (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_event(chan_event), .chan_mask(chan_mask),
        .channel_config(channel_config), .chan_done(chan_done),
        .hw_req(hw_req), .req_done(req_done), .req_out(req_out),
        .tc_irq_out(tc_irq_out), .error_irq_out(error_irq_out),
        .combined_irq_out(combined_irq_out), .evt_irq_out(evt_irq_out));

    dma_periph_model periph (.ref_clk(ref_clk), .hw_req(hw_req),
        .req_done(req_done));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got,
                     exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] ad,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            $display("mismatch at %0t: no bus answer", $time);
            report_and_stop();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d, rdv, errv);
    endtask

    task automatic rd(input logic [11:0] ad, input logic [31:0] exp,
                      input string what);
        apb(1'b0, ad, 32'h0000_0000, rdv, errv);
        chk(rdv, exp, what);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic pulse_evt(input chan_vec_t e);
        @(posedge ref_clk);
        chan_event <= e;
        @(posedge ref_clk);
        chan_event <= '0;
    endtask

    function automatic logic [31:0] irqs();
        return 32'({tc_irq_out, error_irq_out, combined_irq_out});
    endfunction

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {chan_event, chan_mask, channel_config, chan_done} = '0;
        bad_count = 0;
        n_tests = 0;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            rd(12'(`OFF_TC_RAW + 4*k), 32'h0000_0000, "reset");
        end
        apb(1'b0, 12'h030, 32'h0000_0000, rdv, errv);
        chk(32'(errv), 32'h0000_0001, "unmapped err");
        chan_mask <= '{tc: 8'h0F, err: 8'hF0};
        pulse_evt('{tc: 8'hA5, err: 8'h3C});
        rd(`OFF_TC_RAW, 32'h0000_00A5, "tc raw");
        rd(`OFF_ERR_RAW, 32'h0000_003C, "err raw");
        rd(`OFF_TC_MASKED, 32'h0000_0005, "tc masked");
        rd(`OFF_ERR_MASKED, 32'h0000_0030, "err masked");
        rd(`OFF_COMB_MASKED, 32'h0000_0035, "comb masked");
        chk(irqs(), 32'h0000_0007, "irq outs");
        wr(`OFF_TC_CLEAR, 32'h0000_0005);
        rd(`OFF_TC_RAW, 32'h0000_00A0, "tc clear");
        wr(`OFF_ERR_CLEAR, 32'h0000_000C);
        rd(`OFF_ERR_RAW, 32'h0000_0030, "err clear");
        chk(irqs(), 32'h0000_0003, "irq outs");
        wr(`OFF_ERR_CLEAR, 32'h0000_0030);
        rd(`OFF_COMB_MASKED, 32'h0000_0000, "comb clear");
        chk(irqs(), 32'h0000_0000, "irq outs");
        // event status is sticky and cleared by its own read
        rd(`OFF_EVT_STATUS, 32'h0000_0003, "evt status");
        rd(`OFF_EVT_STATUS, 32'h0000_0000, "evt read clear");
        wr(`OFF_EVT_MASK, 32'h0000_0001);
        pulse_evt('{tc: 8'h00, err: 8'h01});
        tick(2);
        chk(32'(evt_irq_out), 32'h0000_0000, "evt masked");
        pulse_evt('{tc: 8'h04, err: 8'h00});
        tick(2);
        chk(32'(evt_irq_out), 32'h0000_0001, "evt irq");
        rd(`OFF_EVT_STATUS, 32'h0000_0003, "evt status");
        tick(2);
        chk(32'(evt_irq_out), 32'h0000_0000, "evt irq clear");
        channel_config <= 8'h81;
        tick(2);
        rd(`OFF_CHAN_ON, 32'h0000_0081, "chan on");
        chan_done <= 8'h80;
        tick(1);
        chan_done <= 8'h00;
        rd(`OFF_CHAN_ON, 32'h0000_0001, "chan done");
        for (int k = 0; k < 4; k++) begin
            a = 12'(`OFF_SW_BURST + 4*k);
            wr(a, 32'h0000_8001);
            wr(a, 32'h0000_0000);
            wr(a, 32'h0000_0100);
            rd(a, 32'h0000_8101, "sw req");
            chk(32'(req_out[(3-k)*NUM_SRC +: NUM_SRC]), 32'h0000_8101,
                "req out");
            periph.serve(16'h8101, k);
            rd(a, 32'h0000_0000, "sw done");
        end
        // serving the software requests flagged the sw done event only
        rd(`OFF_EVT_STATUS, 32'h0000_0004, "sw done evt");
        // hardware lines pass a synchroniser, hence the longer wait
        for (int k = 0; k < 4; k++) begin
            periph.set_req(k, 0, 1'b1);
            tick(7);
            chk(32'(req_out[(3-k)*NUM_SRC]), 32'h0000_0001, "hw");
            periph.set_req(k, 0, 1'b0);
            tick(7);
            chk(32'(req_out[(3-k)*NUM_SRC]), 32'h0000_0000, "hw");
        end
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        report_and_stop();
    end
endmodule

`default_nettype wire
